// File: rtl/cmd_axis_watch.sv
`timescale 1ns/1ns
`default_nettype none
// one axis: deviation compare and settle-window timer
module cmd_axis_watch
  import cmd_pkg::*;
#(
  parameter int ERR_WIDTH = ERR_W,
  parameter int MS_COUNT  = MS_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [ERR_WIDTH-1:0] err_mag,
  input  wire logic [ERR_WIDTH-1:0] bound,
  input  wire logic                 wait_done,
  input  wire logic                 profile_end,
  input  wire logic                 at_target,
  input  wire logic [15:0]          window_ms,
  output logic                      over_bound,
  output logic                      timed_out
);
  typedef struct packed {
    logic [31:0] tick;
    logic [15:0] ms;
    logic        run;
    logic        over;
    logic        tmo;
  } cmd_aw_s;
  cmd_aw_s s_q, s_d;

  // timer starts at profile end, only while a completion point waits
  always_comb begin
    s_d      = s_q;
    s_d.over = err_mag > bound;
    s_d.tmo  = 1'b0;
    if (!wait_done || at_target) begin
      s_d.run = 1'b0;
    end else if (profile_end && !s_q.run) begin
      s_d.run  = 1'b1;
      s_d.tick = '0;
      s_d.ms   = '0;
    end else if (s_q.run) begin
      if (s_q.tick == 32'(MS_COUNT - 1)) begin
        s_d.tick = '0;
        s_d.ms   = s_q.ms + 16'h0001;
        if (s_q.ms + 16'h0001 >= window_ms) begin
          s_d.tmo = 1'b1;
          s_d.run = 1'b0;  // one pulse per missed target
        end
      end else begin
        s_d.tick = s_q.tick + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) s_q <= '0;
    else        s_q <= s_d;
  end

  assign over_bound = s_q.over;
  assign timed_out  = s_q.tmo;
endmodule : cmd_axis_watch
`default_nettype wire

// File: rtl/cmd_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - watch conditions always; dispatch only if the handler label is resident
// - any axis limit input low invokes the limit routine
// - watched digital input going low invokes the input routine
// - axis deviation above its bound invokes the following fault routine
// - settle window missed after profile end invokes the timeout routine
// - bad command invokes the bad command routine only while running
// - at power up start the boot routine
// - checksum fault at boot runs its routine and sets the matching ones of fault bits 0..3
// - limit routine runs only while a program executes
// - limit routine repeats after return while the limit stays active
// - limit routine runs only while that motor is commanded to move
// - host motion commands keep working while a program loops
// - return without rearm goes back without re-enabling trip points
// - jog speed above maximum is a range error and invokes the routine
// - fault code six means range error; fault line gives failing line
// - faulting thread id holds the thread of the last command error
// - again location holds the failed command's location
// - skip location holds the location after the failed command
// - launch at retry or skip with restart flag keeps the stack
// - each handler or call entry pushes one level; end pops it
// - stack trim one drops a level, zero resets the stack
module cmd_monitor
  import cmd_pkg::*;
#(
  parameter int AXES    = NUM_AXES,
  parameter int INPUTS  = NUM_INPUTS,
  parameter int MS_COUNT = MS_CYCLES
) (
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  input  wire logic [NUM_LABELS-1:0]  LABEL_PRESENT,
  input  wire logic                   PROG_RUNNING,
  input  wire logic [AXES-1:0]        LIMIT_N,
  input  wire logic [AXES-1:0]        AXIS_MOVING,
  input  wire logic [INPUTS-1:0]      DIN,
  input  wire logic [INPUTS-1:0]      INPUT_WATCH_MASK,
  input  wire logic [AXES*ERR_W-1:0]  AXIS_ERR,
  input  wire logic [AXES*ERR_W-1:0]  DEVIATION_BOUND,
  input  wire logic [15:0]            SETTLE_WINDOW,
  input  wire logic [AXES-1:0]        WAIT_DONE,
  input  wire logic [AXES-1:0]        PROFILE_END,
  input  wire logic [AXES-1:0]        AT_TARGET,
  input  wire logic                   BAD_CMD,
  input  wire logic                   JOG_CMD,
  input  wire logic [SPEED_W-1:0]     JOG_SPEED,
  input  wire logic [7:0]             CMD_CODE,
  input  wire logic [LINE_W-1:0]      CMD_LINE,
  input  wire logic [2:0]             CMD_THREAD,
  input  wire logic                   BOOT_DONE,
  input  wire logic [3:0]             BOOT_FAULTS,
  input  wire logic                   BACK_TO_MAIN,
  input  wire logic                   BACK_WITHOUT_REARM,
  input  wire logic                   CALL,
  input  wire logic                   END_CMD,
  input  wire logic                   STACK_TRIM,
  input  wire logic                   STACK_TRIM_ARG,
  input  wire logic                   LAUNCH_THREAD,
  input  wire logic                   LAUNCH_RESTART,
  output logic                        DISPATCH,
  output logic [2:0]                  HANDLER,
  output logic                        IN_HANDLER,
  output logic                        TRIP_REARM,
  output logic                        JOG_ACCEPT,
  output logic [3:0]                  STARTUP_FAULT_BITS,
  output logic [7:0]                  FAULT_CODE,
  output logic [LINE_W-1:0]           FAULT_LINE,
  output logic [2:0]                  FAULTING_THREAD_ID,
  output logic [LINE_W-1:0]           AGAIN_LOCATION,
  output logic [LINE_W-1:0]           SKIP_LOCATION,
  output logic [4:0]                  STACK_LEVEL,
  output logic                        KEEP_STACK
);
  localparam int NP = 7;  // pending slots, index = priority order

  typedef struct packed {
    logic [NP-1:0]     pend;
    logic              busy;
    cmd_handler_e      hsel;
    logic              disp;
    logic              rearm;
    logic              jog_ok;
    logic              booted;
    logic [INPUTS-1:0] din_prev;
    logic [3:0]        rs;
    logic [7:0]        code;
    logic [LINE_W-1:0] line;
    logic [2:0]        thr;
    logic [LINE_W-1:0] again;
    logic [LINE_W-1:0] skip;
    logic [4:0]        sp;
    logic              keep;
  } cmd_state_s;
  cmd_state_s s_q, s_d;

  logic [AXES-1:0] over_b;
  logic [AXES-1:0] tmo;

  // one watcher per axis keeps the top file free of per-axis counters
  for (genvar a = 0; a < AXES; a++) begin : g_axis
    cmd_axis_watch #(.ERR_WIDTH(ERR_W), .MS_COUNT(MS_COUNT)) u_watch (
      .clk        (CLK),
      .rst_n      (RST_N),
      .err_mag    (AXIS_ERR[a*ERR_W +: ERR_W]),
      .bound      (DEVIATION_BOUND[a*ERR_W +: ERR_W]),
      .wait_done  (WAIT_DONE[a]),
      .profile_end(PROFILE_END[a]),
      .at_target  (AT_TARGET[a]),
      .window_ms  (SETTLE_WINDOW),
      .over_bound (over_b[a]),
      .timed_out  (tmo[a])
    );
  end

  logic [NP-1:0] ev;
  logic          range_err;
  logic          cmd_err;
  logic          ret;

  always_comb begin
    range_err = JOG_CMD && (JOG_SPEED > JOG_MAX);
    cmd_err   = BAD_CMD || range_err;
    ret       = BACK_TO_MAIN || BACK_WITHOUT_REARM;
    // slot 0 highest priority; each gated by its label being resident
    ev    = '0;
    ev[0] = BOOT_DONE && (|BOOT_FAULTS) && LABEL_PRESENT[IDX_BOOTERR];
    ev[1] = (|(~LIMIT_N & AXIS_MOVING)) && PROG_RUNNING
            && LABEL_PRESENT[IDX_LIMIT];
    ev[2] = (|over_b) && LABEL_PRESENT[IDX_FOLLOW];
    ev[3] = (|tmo) && LABEL_PRESENT[IDX_TIMEOUT];
    ev[4] = (|(s_q.din_prev & ~DIN & INPUT_WATCH_MASK)) && LABEL_PRESENT[IDX_INPUT];
    ev[5] = cmd_err && PROG_RUNNING && LABEL_PRESENT[IDX_BADCMD];
    ev[6] = !s_q.booted && LABEL_PRESENT[IDX_BOOT];
  end

  always_comb begin
    s_d          = s_q;
    s_d.disp     = 1'b0;
    s_d.rearm    = 1'b0;
    s_d.jog_ok   = JOG_CMD && !range_err;  // host motion keeps flowing
    s_d.din_prev = DIN;
    s_d.booted   = 1'b1;
    s_d.keep     = 1'b0;
    if (BOOT_DONE) begin
      s_d.rs[RS_VAR_BIT]  = s_q.rs[RS_VAR_BIT]  | BOOT_FAULTS[RS_VAR_BIT];
      s_d.rs[RS_PAR_BIT]  = s_q.rs[RS_PAR_BIT]  | BOOT_FAULTS[RS_PAR_BIT];
      s_d.rs[RS_PRG_BIT]  = s_q.rs[RS_PRG_BIT]  | BOOT_FAULTS[RS_PRG_BIT];
      s_d.rs[RS_MRST_BIT] = s_q.rs[RS_MRST_BIT] | BOOT_FAULTS[RS_MRST_BIT];
    end
    // fault operands capture the latest bad command
    if (cmd_err) begin
      s_d.code  = range_err ? CODE_RANGE : (BAD_CMD ? CMD_CODE : CODE_BAD);
      s_d.line  = CMD_LINE;
      s_d.thr   = CMD_THREAD;
      s_d.again = CMD_LINE;
      s_d.skip  = CMD_LINE + LINE_W'(1);
    end
    // restart launch keeps the stack instead of clearing it
    s_d.keep = LAUNCH_THREAD && LAUNCH_RESTART;
    // stack: calls push, end pops, trim drops one or clears
    if (CALL && s_q.sp < 5'(STACK_DEPTH)) begin
      s_d.sp = s_q.sp + 5'h01;
    end else if (END_CMD && s_q.sp != 5'h00) begin
      s_d.sp = s_q.sp - 5'h01;
    end else if (STACK_TRIM) begin
      if (!STACK_TRIM_ARG)       s_d.sp = 5'h00;
      else if (s_q.sp != 5'h00)  s_d.sp = s_q.sp - 5'h01;
    end else if (LAUNCH_THREAD && !LAUNCH_RESTART) begin
      s_d.sp = 5'h00;
    end
    // return: resume the program, limit re-queued by level if still active
    if (s_q.busy && ret) begin
      s_d.busy  = 1'b0;
      s_d.rearm = BACK_TO_MAIN;
      s_d.hsel  = CMD_H_NONE;
    end
    // set wins over the dispatch clear: new events fold in first, and the clear reloads the winner from its event
    for (int i = 0; i < NP; i++) begin
      s_d.pend[i] = s_q.pend[i] | ev[i];
    end
    s_d.pend[1] = ev[1];  // limit is a live level, re-run while held
    if (!s_q.busy && !s_q.disp) begin
      for (int i = NP - 1; i >= 0; i--) begin
        if (s_q.pend[i]) begin
          s_d.hsel = cmd_handler_e'(3'(i + 1));
        end
      end
      if (|s_q.pend) begin
        s_d.disp = 1'b1;
        s_d.busy = 1'b1;
        for (int i = 0; i < NP; i++) begin
          if (s_q.pend[i] && !(|(s_q.pend & ((NP'(1) << i) - NP'(1))))) begin
            s_d.pend[i] = ev[i];  // only the winner clears
          end
        end
        // a call in the same cycle has already pushed; the entry adds its own level
        if (s_d.sp < 5'(STACK_DEPTH)) begin
          s_d.sp = s_d.sp + 5'h01;
        end
      end
    end
    // return pops the handler level after any end or trim of this cycle,
    // so a trim to zero is never undercut by the return
    if (s_q.busy && ret && s_d.sp != 5'h00) begin
      s_d.sp = s_d.sp - 5'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) s_q <= '0;
    else        s_q <= s_d;
  end

  assign DISPATCH           = s_q.disp;
  assign HANDLER            = s_q.hsel;
  assign IN_HANDLER         = s_q.busy;
  assign TRIP_REARM         = s_q.rearm;
  assign JOG_ACCEPT         = s_q.jog_ok;
  assign STARTUP_FAULT_BITS = s_q.rs;
  assign FAULT_CODE         = s_q.code;
  assign FAULT_LINE         = s_q.line;
  assign FAULTING_THREAD_ID = s_q.thr;
  assign AGAIN_LOCATION     = s_q.again;
  assign SKIP_LOCATION      = s_q.skip;
  assign STACK_LEVEL        = s_q.sp;
  assign KEEP_STACK         = s_q.keep;

  // checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  dispatch_one_a: assert property (DISPATCH |=> !DISPATCH)
    else $error("dispatch lasted more than one cycle");
  no_label_a: assert property ($rose(s_q.pend[5]) |-> $past(LABEL_PRESENT[IDX_BADCMD]))
    else $error("dispatch without resident label");
  badcmd_idle_a: assert property ($rose(s_q.pend[5]) |-> $past(PROG_RUNNING))
    else $error("bad command handler armed with no program");
  range_code_a: assert property (range_err |=> FAULT_CODE == CODE_RANGE)
    else $error("range fault code not stored");
  skip_next_a: assert property (cmd_err |=> SKIP_LOCATION == $past(CMD_LINE) + LINE_W'(1))
    else $error("skip location not after failed command");
  thread_cap_a: assert property (cmd_err |=> FAULTING_THREAD_ID == $past(CMD_THREAD))
    else $error("faulting thread not captured");
  rearm_rule_a: assert property (IN_HANDLER && BACK_WITHOUT_REARM && !BACK_TO_MAIN
                                 |=> !TRIP_REARM && !IN_HANDLER)
    else $error("rearm after return without rearm");
  trim_zero_a: assert property (STACK_TRIM && !STACK_TRIM_ARG && !CALL && !END_CMD
                                && (IN_HANDLER || s_q.pend == '0) |=> STACK_LEVEL == 5'h00)
    else $error("stack not cleared");
  limit_gate_a: assert property (s_q.pend[1] |-> $past(PROG_RUNNING && (|(~LIMIT_N & AXIS_MOVING))))
    else $error("limit event without motion");
  boot_bits_a: assert property (BOOT_DONE |=> (STARTUP_FAULT_BITS & $past(BOOT_FAULTS)) == $past(BOOT_FAULTS))
    else $error("startup fault bit not recorded");
  boot_err_a: assert property ($rose(s_q.pend[0]) |-> $past(BOOT_DONE && (|BOOT_FAULTS)))
    else $error("checksum routine pending without a fault");
  follow_src_a: assert property ($rose(s_q.pend[2]) |-> $past(|over_b))
    else $error("deviation routine pending without an axis over bound");
  timeout_src_a: assert property ($rose(s_q.pend[3]) |-> $past(|tmo))
    else $error("timeout routine pending without a missed window");
  busy_hold_a: assert property (IN_HANDLER && !BACK_TO_MAIN && !BACK_WITHOUT_REARM
                                |=> IN_HANDLER && $stable(HANDLER))
    else $error("routine left or changed without a return");
  return_rearm_a: assert property (IN_HANDLER && BACK_TO_MAIN |=> TRIP_REARM && !IN_HANDLER)
    else $error("return did not resume with rearm");
  jog_pass_a: assert property (JOG_CMD && (JOG_SPEED <= JOG_MAX) |=> JOG_ACCEPT)
    else $error("legal jog not accepted");
  keep_flag_a: assert property (LAUNCH_THREAD && LAUNCH_RESTART |=> KEEP_STACK)
    else $error("restart launch did not keep the stack");
  c_limit: cover property (DISPATCH && HANDLER == CMD_H_LIMIT);
  c_badcmd: cover property (DISPATCH && HANDLER == CMD_H_BADCMD);
  c_ret: cover property (IN_HANDLER ##1 !IN_HANDLER);
  c_timeout: cover property (DISPATCH && HANDLER == CMD_H_TIMEOUT);
  c_input: cover property (DISPATCH && HANDLER == CMD_H_INPUT);
endmodule : cmd_monitor
`default_nettype wire

// File: rtl/cmd_pkg.sv
package cmd_pkg;
  localparam int          NUM_AXES       = 8;
  localparam int          NUM_INPUTS     = 8;
  localparam int          NUM_THREADS    = 8;
  localparam int          LINE_W         = 12;
  localparam int          ERR_W          = 16;
  localparam int          SPEED_W        = 24;
  localparam int          STACK_DEPTH    = 16;
  localparam int          CLK_MHZ        = 25;
  // wait period unit is one millisecond
  localparam int          MS_CYCLES      = CLK_MHZ * 1000;
  localparam logic [23:0] JOG_MAX        = 24'h7A_1200;  // 8 million
  localparam logic [7:0]  CODE_RANGE     = 8'h06;
  localparam logic [7:0]  CODE_BAD       = 8'h01;
  localparam int          RS_VAR_BIT     = 0;
  localparam int          RS_PAR_BIT     = 1;
  localparam int          RS_PRG_BIT     = 2;
  localparam int          RS_MRST_BIT    = 3;
  // handler select codes, one per monitored condition, priority order
  typedef enum logic [2:0] {
    CMD_H_NONE, CMD_H_BOOT_ERR, CMD_H_LIMIT, CMD_H_FOLLOW,
    CMD_H_TIMEOUT, CMD_H_INPUT, CMD_H_BADCMD, CMD_H_BOOT
  } cmd_handler_e;
  localparam int          IDX_LIMIT      = 0;
  localparam int          IDX_INPUT      = 1;
  localparam int          IDX_FOLLOW     = 2;
  localparam int          IDX_TIMEOUT    = 3;
  localparam int          IDX_BADCMD     = 4;
  localparam int          IDX_BOOTERR    = 5;
  localparam int          IDX_BOOT       = 6;
  localparam int          NUM_LABELS     = 7;
endpackage : cmd_pkg

// File: test/cmd_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
// resident program: every dispatched routine leaves after a short body
module cmd_prog_model
  import cmd_pkg::*;
#(
  parameter int RET_DELAY = 5
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic dispatch,
  input  wire logic no_rearm,
  output logic      back_to_main,
  output logic      back_without_rearm
);
  int cnt_q = 0;

  // returns are driven off the falling edge, one cycle wide
  always @(negedge clk) begin
    back_to_main       <= 1'b0;
    back_without_rearm <= 1'b0;
    if (!rst_n) begin
      cnt_q <= 0;
    end else if (dispatch === 1'b1) begin
      cnt_q <= RET_DELAY;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      // every routine ends in one of the two return commands
      if (cnt_q == 1 && no_rearm) back_without_rearm <= 1'b1;
      if (cnt_q == 1 && !no_rearm) back_to_main <= 1'b1;
    end
  end
endmodule : cmd_prog_model
`default_nettype wire

// File: test/tb_condition_monitor_dispatch.sv
`timescale 1ns/1ns
`default_nettype none
module tb_condition_monitor_dispatch;
  import cmd_pkg::*;
  // pulse inputs share one vector so a task can raise any of them
  logic [7:0] p = '0;
  wire BAD_CMD = p[0], JOG_CMD = p[1], BOOT_DONE = p[2], CALL = p[3];
  wire END_CMD = p[4], STACK_TRIM = p[5], LAUNCH_THREAD = p[6];
  logic CLK = 1'b0, RST_N = 1'b0, PROG_RUNNING = 1'b1;
  logic STACK_TRIM_ARG = 1'b0, LAUNCH_RESTART = 1'b0, no_rearm = 1'b0;
  logic [NUM_LABELS-1:0] LABEL_PRESENT = 7'h7F;
  logic [7:0] LIMIT_N = 8'hFF, AXIS_MOVING = 8'hFF, DIN = 8'hFF, INPUT_WATCH_MASK = 8'h02;
  logic [7:0] WAIT_DONE = '0, PROFILE_END = '0, AT_TARGET = '0, CMD_CODE = '0;
  logic [NUM_AXES*ERR_W-1:0] AXIS_ERR = '0, DEVIATION_BOUND = {8{16'h0100}};
  logic [15:0] SETTLE_WINDOW = 16'h0003;
  logic [SPEED_W-1:0] JOG_SPEED = '0;
  logic [LINE_W-1:0] CMD_LINE = '0;
  logic [2:0] CMD_THREAD = '0;
  logic [3:0] BOOT_FAULTS = '0;
  wire BACK_TO_MAIN, BACK_WITHOUT_REARM, DISPATCH, IN_HANDLER, TRIP_REARM, JOG_ACCEPT, KEEP_STACK;
  wire [2:0] HANDLER, FAULTING_THREAD_ID;
  wire [3:0] STARTUP_FAULT_BITS;
  wire [7:0] FAULT_CODE;
  wire [LINE_W-1:0] FAULT_LINE, AGAIN_LOCATION, SKIP_LOCATION;
  wire [4:0] STACK_LEVEL;
  int n_fail = 0, samples_checked = 0, n_rearm = 0, n_acc = 0, n_keep = 0, r0;
  logic [2:0] disp_q[$];

  // short millisecond keeps the settle window at twelve cycles
  cmd_monitor #(.MS_COUNT(4)) uut (.*);
  cmd_prog_model prog (.clk(CLK), .rst_n(RST_N), .dispatch(DISPATCH), .no_rearm(no_rearm),
                       .back_to_main(BACK_TO_MAIN), .back_without_rearm(BACK_WITHOUT_REARM));

  initial forever #20 CLK = ~CLK;

  // one-cycle outputs are logged mid-cycle, where they are settled
  always @(negedge CLK) begin
    if (DISPATCH === 1'b1) disp_q.push_back(HANDLER);
    if (TRIP_REARM === 1'b1) n_rearm++;
    if (JOG_ACCEPT === 1'b1) n_acc++;
    if (KEEP_STACK === 1'b1) n_keep++;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : cyc

  task pulse(input logic [7:0] m);
    @(negedge CLK);
    p = m;
    @(negedge CLK);
    p = '0;
  endtask : pulse

  // bounded wait for the next dispatch, then compare its routine
  task expect_disp(input logic [2:0] h);
    int k;
    k = 0;
    while (disp_q.size() == 0 && k < 60) begin
      @(negedge CLK);
      k++;
    end
    check(disp_q.size() == 0 ? 32'hFFFF_FFFF : disp_q.pop_front(), h);
  endtask : expect_disp

  task expect_none(input int n);
    cyc(n);
    check(disp_q.size(), 0);
  endtask : expect_none

  task settle(input string name);
    int k;
    k = 0;
    while (IN_HANDLER !== 1'b0 && k < 60) begin
      @(negedge CLK);
      k++;
    end
    cyc(3);
    $display("test %s finished", name);
  endtask : settle

  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    conclude();
  end

  initial begin
    cyc(5);
    RST_N = 1'b1;
    expect_disp(CMD_H_BOOT);
    settle("boot");
    BOOT_FAULTS = 4'hB;
    pulse(8'h04);
    expect_disp(CMD_H_BOOT_ERR);
    check(STARTUP_FAULT_BITS, 4'hB);
    settle("boot fault");
    check(n_rearm, 2);
    // refusals: not running, label missing, axis not commanded
    PROG_RUNNING = 1'b0;
    LIMIT_N = 8'hFE;
    pulse(8'h01);
    expect_none(20);
    LIMIT_N = 8'hFF;
    PROG_RUNNING = 1'b1;
    LABEL_PRESENT = 7'h6F;
    pulse(8'h01);
    expect_none(20);
    LABEL_PRESENT = 7'h7F;
    AXIS_MOVING = 8'hFD;
    LIMIT_N = 8'hFD;
    expect_none(20);
    LIMIT_N = 8'hFF;
    AXIS_MOVING = 8'hFF;
    $display("test refusals finished");
    CMD_CODE = CODE_BAD;
    CMD_LINE = 12'h02A;
    CMD_THREAD = 3'h5;
    pulse(8'h01);
    check(FAULT_CODE, CODE_BAD);
    check(FAULT_LINE, 12'h02A);
    check(FAULTING_THREAD_ID, 3'h5);
    check(AGAIN_LOCATION, 12'h02A);
    check(SKIP_LOCATION, 12'h02B);
    expect_disp(CMD_H_BADCMD);
    check(STACK_LEVEL, 1);
    settle("operands");
    // jog speed at and just above the maximum
    JOG_SPEED = JOG_MAX;
    pulse(8'h02);
    cyc(1);
    check(n_acc, 1);
    expect_none(10);
    JOG_SPEED = JOG_MAX + 24'h00_0001;
    pulse(8'h02);
    check(FAULT_CODE, CODE_RANGE);
    expect_disp(CMD_H_BADCMD);
    settle("jog");
    LIMIT_N = 8'hEF;
    expect_disp(CMD_H_LIMIT);
    expect_disp(CMD_H_LIMIT);
    LIMIT_N = 8'hFF;
    settle("limit");
    @(negedge CLK);
    LIMIT_N = 8'h7F;
    p = 8'h01;
    @(negedge CLK);
    p = '0;
    expect_disp(CMD_H_LIMIT);
    LIMIT_N = 8'hFF;
    expect_disp(CMD_H_BADCMD);
    settle("priority");
    AXIS_ERR[3*16+:16] = 16'h0100;
    expect_none(10);
    // one cycle over the bound, so the level cannot re-pend during the routine
    AXIS_ERR[3*16+:16] = 16'h0101;
    @(negedge CLK);
    AXIS_ERR = '0;
    expect_disp(CMD_H_FOLLOW);
    expect_none(12);
    settle("deviation");
    no_rearm = 1'b1;
    r0 = n_rearm;
    DIN = 8'hFE;
    expect_none(10);
    DIN = 8'hFC;
    expect_disp(CMD_H_INPUT);
    settle("input");
    check(n_rearm, r0);
    no_rearm = 1'b0;
    DIN = 8'hFF;
    // window of three units, each four cycles long
    WAIT_DONE = 8'h01;
    @(negedge CLK);
    PROFILE_END = 8'h01;
    @(negedge CLK);
    PROFILE_END = 8'h00;
    expect_none(8);
    expect_disp(CMD_H_TIMEOUT);
    WAIT_DONE = 8'h00;
    settle("timeout");
    // reaching the target inside the window cancels the timer
    WAIT_DONE = 8'h01;
    PROFILE_END = 8'h01;
    @(negedge CLK);
    PROFILE_END = 8'h00;
    cyc(4);
    AT_TARGET = 8'h01;
    expect_none(20);
    AT_TARGET = 8'h00;
    WAIT_DONE = 8'h00;
    $display("test target reached finished");
    pulse(8'h08);
    pulse(8'h08);
    check(STACK_LEVEL, 2);
    STACK_TRIM_ARG = 1'b1;
    pulse(8'h20);
    check(STACK_LEVEL, 1);
    LAUNCH_RESTART = 1'b1;
    pulse(8'h40);
    cyc(1);
    check(STACK_LEVEL, 1);
    check(n_keep, 1);
    LAUNCH_RESTART = 1'b0;
    pulse(8'h08);
    pulse(8'h08);
    STACK_TRIM_ARG = 1'b0;
    pulse(8'h20);
    check(STACK_LEVEL, 0);
    pulse(8'h08);
    pulse(8'h10);
    check(STACK_LEVEL, 0);
    $display("test stack finished");
    conclude();
  end
endmodule : tb_condition_monitor_dispatch
`default_nettype wire
